// file: hw/ovps_defs.vh
// Constants for the protected load switch control block.
// Assumes a 20 MHz clock and a classic Wishbone register port.
`ifndef OVPS_DEFS_VH
`define OVPS_DEFS_VH

// ========================================
// Register byte addresses (printed offsets)
`define OVPS_A_ENABLE    8'h04
`define OVPS_A_STATUS    8'h08
`define OVPS_A_FLAG      8'h0c
`define OVPS_A_OVSEL     8'h14
`define OVPS_A_CURSRC    8'h18
`define OVPS_A_TIMING    8'h1c
`define OVPS_A_MEASURED  8'h20
`define OVPS_A_TARGET    8'h24
`define OVPS_A_EXTRA     8'h38
`define OVPS_A_SLEW      8'h3c

// ========================================
// Field positions
`define OVPS_EN_OUTSW    7
`define OVPS_EN_DETECT   6
`define OVPS_ST_BELOW    6
`define OVPS_ST_TMR      5
`define OVPS_ST_SWON     4
`define OVPS_ST_OTG      3
`define OVPS_FL_OV       2
`define OVPS_FL_OC       1
`define OVPS_FL_OT       0

// ========================================
// Reset values
`define OVPS_RST_SLEW    3'h4
`define OVPS_RST_OVSEL   2'h0
`define OVPS_RST_TRIM    3'h3
`define OVPS_RST_CURSRC  4'h0

// ========================================
// Timing
`define OVPS_CLK_KHZ     20000
`define OVPS_DEBOUNCE_MS 13
`define OVPS_DEBOUNCE_CYC (`OVPS_DEBOUNCE_MS * `OVPS_CLK_KHZ)
`define OVPS_SLEW_US_0   420
`define OVPS_SLEW_US_1   440
`define OVPS_SLEW_US_2   500
`define OVPS_SLEW_US_3   650
`define OVPS_SLEW_US_4   900
`define OVPS_SLEW_US_5   1500
`define OVPS_SLEW_US_6   2800
`define OVPS_SLEW_US_7   5600
`define OVPS_CYC_PER_US  20

`endif

// file: hw/ovps_sync.v
// Two-flop synchroniser bank for asynchronous pin levels.
// Assumes inputs come from outside the clk domain.
`timescale 1ns/1ps
module ovps_sync #(
    parameter W = 1
) (
    input  wire         clk,
    input  wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;
    // ========================================
    // First stage feeds only the second stage
    // No reset: pins stay tracked through reset, so no false
    // enable or strap level shows up when reset is released
    always @(posedge clk) begin
        meta_q <= async_in;
        sync_q <= meta_q;
    end
    assign sync_out = sync_q;
endmodule

// file: hw/ovps_ctrl.v
// Control logic of a protected power-path load switch.
// Assumes comparator pins are asynchronous, registers on classic Wishbone.
//
// Behaviour
// - Enable pin high keeps switch off, protections and detection idle.
// - A 13 ms debounce restarts on every turn-on attempt.
// - Overtemperature during reverse OTG flow only interrupts, no forced off.
// - Three-bit slew code picks ramp 0.42 to 5.6 ms, reset 0.9 ms.
// - Enabled with rail under undervoltage threshold keeps switch off.
// - Rail above undervoltage, no fault: switch turns on, ignoring enable bit.
// - Overvoltage turns switch off, sets flag, interrupts; resumes after.
// - Power-up threshold from adjust pin, internal default below 0.1 V.
// - Two-bit threshold select chooses 6.8, 11.5, 17 or 23 V.
// - Extra select codes 10 and 11 override with 10 V or 14 V.
// - Three-bit trim offsets register threshold in 200 mV steps.
// - Overtemperature above 140 C turns off, flags; below 115 C resumes.
// - Overcurrent after full turn-on turns off, flags, interrupts.
// - Detection only under undervoltage; leaves at once when rail rises.
// - Result valid at pulse timer expiry; sets done bit, interrupts.
// - Measured below target sets below-target status and interrupts.
// - Four-bit source current code, zero selects no current.
// - Interrupt on any flag, below-target or timer-done status rising edge, latched.
// - Fault flags clear only on flag read or rail under undervoltage.
//
// The placing of the registers and the Wishbone slave port were decided locally.
`timescale 1ns/1ps
`include "ovps_defs.vh"
module ovps_ctrl #(
    parameter DEBOUNCE_CYC = `OVPS_DEBOUNCE_CYC,
    parameter CYC_PER_US   = `OVPS_CYC_PER_US,
    parameter PW_UNIT_CYC  = 4000
) (
    input  wire        clk,
    input  wire        rst,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire        enable_n,
    input  wire        uvlo_above,
    input  wire        ovp_above,
    input  wire        temp_hot,
    input  wire        temp_cool,
    input  wire        curr_over,
    input  wire        otg_reverse,
    input  wire        adjust_above_min,
    input  wire [7:0]  measured_level,
    output reg         switch_on,
    output reg         ramp_active,
    output reg         int_n,
    output reg         use_adjust_pin,
    output reg  [3:0]  ovp_code,
    output reg  [2:0]  threshold_trim,
    output reg  [3:0]  source_current_code,
    output reg         detect_active
);
    wire [7:0] pins_s;
    wire       en_s   = ~pins_s[0];
    wire       uv_ok  = pins_s[1];
    wire       ov_s   = pins_s[2];
    wire       hot_s  = pins_s[3];
    wire       cool_s = pins_s[4];
    wire       oc_s   = pins_s[5];
    wire       otg_s  = pins_s[6];
    wire       strap_s = pins_s[7];

    ovps_sync #(.W(8)) u_sync (
        .clk      (clk),
        .async_in ({adjust_above_min, otg_reverse, curr_over, temp_cool,
                    temp_hot, ovp_above, uvlo_above, enable_n}),
        .sync_out (pins_s)
    );

    // ========================================
    // Registers
    reg        outsw_en_q;
    reg        detect_en_q;
    reg [1:0]  ovsel_q;
    reg [1:0]  extra_q;
    reg [2:0]  trim_q;
    reg [2:0]  slew_q;
    reg [3:0]  cursrc_q;
    reg [7:0]  timing_q;
    reg [7:0]  target_q;
    reg [7:0]  meas_q;
    reg [2:0]  flag_q;
    reg        below_q;
    reg        tmr_done_q;
    reg        host_set_q;
    reg        ot_latch_q;
    reg        strap_cap_q;
    reg        full_on_q;
    reg [4:0]  irq_src_q;
    reg        irq_q;
    reg [27:0] deb_cnt_q;
    reg [17:0] ramp_cnt_q;
    reg [31:0] det_cnt_q;

    wire acc     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr      = acc & wb_we_i & wb_sel_i[0];
    wire rd_flag = acc & ~wb_we_i & (wb_adr_i == `OVPS_A_FLAG);

    // ========================================
    // Fault evaluation
    // thermal hysteresis
    wire ot_next  = hot_s ? 1'b1 : (cool_s ? 1'b0 : ot_latch_q);
    wire ot_block = ot_latch_q & ~otg_s;
    wire fault    = ov_s | ot_block | (oc_s & full_on_q) | ~uv_ok;
    wire want_on  = en_s & ~fault;

    reg [31:0] ramp_us;
    always @* begin
        case (slew_q)
            3'h0: ramp_us = `OVPS_SLEW_US_0;
            3'h1: ramp_us = `OVPS_SLEW_US_1;
            3'h2: ramp_us = `OVPS_SLEW_US_2;
            3'h3: ramp_us = `OVPS_SLEW_US_3;
            3'h4: ramp_us = `OVPS_SLEW_US_4;
            3'h5: ramp_us = `OVPS_SLEW_US_5;
            3'h6: ramp_us = `OVPS_SLEW_US_6;
            default: ramp_us = `OVPS_SLEW_US_7;
        endcase
    end
    // Longest ramp at the default clock still fits in 18 bits
    wire [31:0] ramp_full = ramp_us * CYC_PER_US;
    wire [17:0] ramp_len  = ramp_full[17:0];

    // ========================================
    // Switch sequencer, one-hot
    localparam S_OFF = 4'b0001;
    localparam S_DEB = 4'b0010;
    localparam S_RMP = 4'b0100;
    localparam S_ON  = 4'b1000;
    reg [3:0] st_q;

    always @(posedge clk) begin
        if (rst) begin
            st_q       <= S_OFF;
            deb_cnt_q  <= 28'h0000000;
            ramp_cnt_q <= 18'h00000;
            full_on_q  <= 1'b0;
            ot_latch_q <= 1'b0;
        end else begin
            ot_latch_q <= en_s & ot_next;
            case (st_q)
                S_OFF: begin
                    full_on_q <= 1'b0;
                    deb_cnt_q <= 28'h0000000;
                    if (want_on)
                        st_q <= S_DEB;
                end
                S_DEB: begin
                    if (!want_on) begin
                        st_q <= S_OFF;
                    end else if (deb_cnt_q == DEBOUNCE_CYC - 1) begin
                        st_q       <= S_RMP;
                        ramp_cnt_q <= 18'h00000;
                    end else begin
                        deb_cnt_q <= deb_cnt_q + 28'h0000001;
                    end
                end
                S_RMP: begin
                    if (!want_on) begin
                        st_q <= S_OFF;
                    end else if (ramp_cnt_q >= ramp_len - 18'h00001) begin
                        st_q      <= S_ON;
                        full_on_q <= 1'b1;
                    end else begin
                        ramp_cnt_q <= ramp_cnt_q + 18'h00001;
                    end
                end
                S_ON: begin
                    if (!want_on) begin
                        st_q      <= S_OFF;
                        full_on_q <= 1'b0;
                    end
                end
                default: st_q <= S_OFF;
            endcase
        end
    end

    // ========================================
    // Threshold selection
    always @(posedge clk) begin
        if (rst) begin
            strap_cap_q    <= 1'b0;
            host_set_q     <= 1'b0;
            use_adjust_pin <= 1'b0;
            ovp_code       <= 4'h0;
            threshold_trim <= `OVPS_RST_TRIM;
        end else begin
            if (!strap_cap_q) begin
                strap_cap_q    <= 1'b1;
                use_adjust_pin <= strap_s;
            end else if (host_set_q) begin
                use_adjust_pin <= 1'b0;
            end
            if (wr && (wb_adr_i == `OVPS_A_OVSEL ||
                       wb_adr_i == `OVPS_A_EXTRA))
                host_set_q <= 1'b1;
            ovp_code <= extra_q[1] ? {3'h2, extra_q[0]} : {2'h0, ovsel_q};
            threshold_trim <= host_set_q ? trim_q : `OVPS_RST_TRIM;
        end
    end

    // ========================================
    // Impedance detection
    // only while rail is low
    wire det_allowed = en_s & ~uv_ok & outsw_en_q & detect_en_q;
    wire det_cfg_wr  = wr & (wb_adr_i == `OVPS_A_CURSRC ||
                             wb_adr_i == `OVPS_A_TIMING ||
                             wb_adr_i == `OVPS_A_TARGET);
    wire [3:0] pw_code = timing_q[7:4];
    reg  [31:0] pw_len;
    always @* begin
        pw_len = PW_UNIT_CYC << pw_code;
    end

    always @(posedge clk) begin
        if (rst) begin
            det_cnt_q     <= 32'h00000000;
            detect_active <= 1'b0;
            tmr_done_q    <= 1'b0;
            below_q       <= 1'b0;
            meas_q        <= 8'h00;
        end else if (!det_allowed) begin
            det_cnt_q     <= 32'h00000000;
            detect_active <= 1'b0;
        end else begin
            detect_active <= 1'b1;
            // Setup writes restart the pulse so the result uses them
            if (!detect_active || det_cfg_wr) begin
                tmr_done_q <= 1'b0;
                det_cnt_q  <= 32'h00000000;
            end else if (pw_code != 4'hf && !tmr_done_q) begin
                if (det_cnt_q >= pw_len - 32'h00000001) begin
                    tmr_done_q <= 1'b1;
                    meas_q     <= measured_level;
                    below_q    <= (measured_level < target_q);
                end else begin
                    det_cnt_q <= det_cnt_q + 32'h00000001;
                end
            end
        end
    end

    // ========================================
    // Register file
    always @(posedge clk) begin
        if (rst) begin
            outsw_en_q  <= 1'b0;
            detect_en_q <= 1'b0;
            ovsel_q     <= `OVPS_RST_OVSEL;
            extra_q     <= 2'h0;
            trim_q      <= `OVPS_RST_TRIM;
            slew_q      <= `OVPS_RST_SLEW;
            cursrc_q    <= `OVPS_RST_CURSRC;
            timing_q    <= 8'h00;
            target_q    <= 8'h00;
        end else if (wr) begin
            case (wb_adr_i)
                `OVPS_A_ENABLE: begin
                    outsw_en_q  <= wb_dat_i[`OVPS_EN_OUTSW];
                    detect_en_q <= wb_dat_i[`OVPS_EN_DETECT];
                end
                `OVPS_A_OVSEL: begin
                    ovsel_q <= wb_dat_i[1:0];
                    trim_q  <= wb_dat_i[6:4];
                end
                `OVPS_A_CURSRC: cursrc_q <= wb_dat_i[3:0];
                `OVPS_A_TIMING: timing_q <= wb_dat_i[7:0];
                `OVPS_A_TARGET: target_q <= wb_dat_i[7:0];
                `OVPS_A_EXTRA:  extra_q  <= wb_dat_i[1:0];
                `OVPS_A_SLEW:   slew_q   <= wb_dat_i[2:0];
                default: ;
            endcase
        end
    end

    // ========================================
    // Fault flags, set wins over read clear
    wire [2:0] flag_set;
    assign flag_set[`OVPS_FL_OV] = en_s & ov_s;
    assign flag_set[`OVPS_FL_OC] = en_s & oc_s & full_on_q;
    assign flag_set[`OVPS_FL_OT] = en_s & hot_s;
    always @(posedge clk) begin
        if (rst)
            flag_q <= 3'h0;
        // clear on read or low rail
        else
            flag_q <= flag_set |
                      ((rd_flag | ~uv_ok) ? 3'h0 : flag_q);
    end

    // ========================================
    // Interrupt, one-shot per rising source
    wire [4:0] irq_src = {below_q, tmr_done_q, flag_q};
    always @(posedge clk) begin
        if (rst) begin
            irq_src_q <= 5'h00;
            irq_q     <= 1'b0;
            int_n     <= 1'b1;
        end else begin
            irq_src_q <= irq_src;
            if (!en_s)
                irq_q <= 1'b0;
            else if (|(irq_src & ~irq_src_q))
                irq_q <= 1'b1;
            else if (rd_flag)
                irq_q <= 1'b0;
            int_n <= ~irq_q;
        end
    end

    // ========================================
    // Outputs and bus answer, one wait-free cycle
    always @(posedge clk) begin
        if (rst) begin
            switch_on           <= 1'b0;
            ramp_active         <= 1'b0;
            source_current_code <= 4'h0;
            wb_ack_o            <= 1'b0;
            wb_dat_o            <= 32'h00000000;
        end else begin
            switch_on   <= (st_q == S_RMP) | (st_q == S_ON);
            ramp_active <= (st_q == S_RMP);
            source_current_code <= detect_active ? cursrc_q : 4'h0;
            wb_ack_o <= acc;
            wb_dat_o <= 32'h00000000;
            if (acc && !wb_we_i) begin
                case (wb_adr_i)
                    `OVPS_A_ENABLE:
                        wb_dat_o[7:6] <= {outsw_en_q, detect_en_q};
                    `OVPS_A_STATUS:
                        wb_dat_o[7:3] <= {1'b0, below_q, tmr_done_q,
                                          full_on_q, otg_s};
                    `OVPS_A_FLAG:     wb_dat_o[2:0] <= flag_q;
                    `OVPS_A_OVSEL:
                        wb_dat_o[6:0] <= {trim_q, 2'h0, ovsel_q};
                    `OVPS_A_CURSRC:   wb_dat_o[3:0] <= cursrc_q;
                    `OVPS_A_TIMING:   wb_dat_o[7:0] <= timing_q;
                    `OVPS_A_MEASURED: wb_dat_o[7:0] <= meas_q;
                    `OVPS_A_TARGET:   wb_dat_o[7:0] <= target_q;
                    `OVPS_A_EXTRA:    wb_dat_o[1:0] <= extra_q;
                    `OVPS_A_SLEW:     wb_dat_o[2:0] <= slew_q;
                    default: ;
                endcase
            end
        end
    end
endmodule

// file: testbench/ovps_props.sv
// Checker for the protected load switch control block.
// Assumes it is bound to ovps_ctrl and sees only its ports.
`timescale 1ns/1ps
module ovps_props #(
    parameter DEBOUNCE_CYC = 50
) (
    input wire       clk,
    input wire       rst,
    input wire       wb_cyc_i,
    input wire       wb_stb_i,
    input wire       wb_ack_o,
    input wire       enable_n,
    input wire       uvlo_above,
    input wire       ovp_above,
    input wire       temp_hot,
    input wire       otg_reverse,
    input wire       switch_on,
    input wire       ramp_active,
    input wire       int_n,
    input wire       detect_active,
    input wire [3:0] source_current_code
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ========================================
    // Cycles for which the pins have allowed turn-on
    reg [31:0] ok_cnt_q;
    always @(posedge clk) begin
        if (rst || enable_n || !uvlo_above || ovp_above || temp_hot)
            ok_cnt_q <= 32'h0;
        else if (ok_cnt_q != 32'hffffffff)
            ok_cnt_q <= ok_cnt_q + 32'h1;
    end
    // Margin of five edges covers the two-flop pin synchronisers
    property p_dis;
        enable_n [*5] |-> !switch_on && !detect_active && int_n;
    endproperty
    a_dis: assert property (p_dis) else $error("active while disabled");
    property p_uv;
        !uvlo_above [*5] |-> !switch_on;
    endproperty
    a_uv: assert property (p_uv) else $error("on under UV");
    property p_ov;
        (ovp_above && !enable_n) [*5] |-> !switch_on;
    endproperty
    a_ov: assert property (p_ov) else $error("on during OV");
    property p_ov_int;
        $rose(ovp_above) && !enable_n && uvlo_above |-> ##[1:8] !int_n;
    endproperty
    a_ov_int: assert property (p_ov_int) else $error("no OV int");
    property p_ot;
        (temp_hot && !otg_reverse && !enable_n) [*5] |-> !switch_on;
    endproperty
    a_ot: assert property (p_ot) else $error("on during OT");
    property p_deb;
        $rose(switch_on) |-> ok_cnt_q >= DEBOUNCE_CYC;
    endproperty
    a_deb: assert property (p_deb) else $error("debounce short");
    property p_ramp;
        $rose(switch_on) |-> ramp_active;
    endproperty
    a_ramp: assert property (p_ramp) else $error("no ramp");
    property p_det;
        uvlo_above [*5] |-> !detect_active;
    endproperty
    a_det: assert property (p_det) else $error("detect above UV");
    property p_isrc;
        !detect_active [*2] |-> source_current_code == 4'h0;
    endproperty
    a_isrc: assert property (p_isrc) else $error("idle current");
    property p_ack;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("bad ack");
endmodule

bind ovps_ctrl ovps_props #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) ovps_props_i (
    .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .enable_n(enable_n), .uvlo_above(uvlo_above),
    .ovp_above(ovp_above), .temp_hot(temp_hot), .otg_reverse(otg_reverse),
    .switch_on(switch_on), .ramp_active(ramp_active), .int_n(int_n),
    .detect_active(detect_active),
    .source_current_code(source_current_code));

// file: testbench/ovps_host.sv
// Host model: classic Wishbone master for the register port.
// Assumes a registered one-cycle ack from the slave.
`timescale 1ns/1ps
module ovps_host (
    input  wire        clk,
    output reg         cyc,
    output reg         stb,
    output reg         we,
    output reg  [7:0]  adr,
    output reg  [3:0]  sel,
    output reg  [31:0] dat,
    input  wire        ack,
    input  wire [31:0] rdat
);
    initial begin
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'h0;
        dat = 32'h0;
    end
    // ========================================
    // host register access
    // Ack and read data are taken at the rising edge that sees ack
    task automatic xfer(input w, input [7:0] a, input [7:0] d,
                        output [7:0] q);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hf;
        dat <= {24'h0, d};
        @(posedge clk);
        while (ack !== 1'b1)
            @(posedge clk);
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
endmodule

// file: testbench/ovps_ctrl_bench.sv
// Self-checking bench for the load switch control block.
// Assumes shortened debounce, pulse and ramp counts set below.
`timescale 1ns/1ps
`include "ovps_defs.vh"
module ovps_ctrl_bench;
    localparam int DEB = 50;
    localparam int RAMP0 = `OVPS_SLEW_US_0;
    reg        clk, rst, enable_n, uvlo_above, ovp_above, temp_hot;
    reg        temp_cool, curr_over, otg_reverse, adjust_above_min;
    reg  [7:0] measured_level, q, tgt;
    reg  [31:0] rnd_q;
    wire       cyc, stb, we, ack, switch_on, ramp_active, int_n;
    wire       use_adjust_pin, detect_active;
    wire [7:0] adr;
    wire [3:0] sel, ovp_code, source_current_code;
    wire [2:0] threshold_trim;
    wire [31:0] dat, rdat;
    int        error_cnt, samples_checked, n;

    ovps_host ovps_host_i (.clk(clk), .cyc(cyc), .stb(stb), .we(we),
        .adr(adr), .sel(sel), .dat(dat), .ack(ack), .rdat(rdat));
    ovps_ctrl #(.DEBOUNCE_CYC(DEB), .CYC_PER_US(1), .PW_UNIT_CYC(4))
    ovps_ctrl_i (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .enable_n(enable_n),
        .uvlo_above(uvlo_above), .ovp_above(ovp_above),
        .temp_hot(temp_hot), .temp_cool(temp_cool),
        .curr_over(curr_over), .otg_reverse(otg_reverse),
        .adjust_above_min(adjust_above_min),
        .measured_level(measured_level),
        .switch_on(switch_on), .ramp_active(ramp_active), .int_n(int_n),
        .use_adjust_pin(use_adjust_pin), .ovp_code(ovp_code),
        .threshold_trim(threshold_trim),
        .source_current_code(source_current_code),
        .detect_active(detect_active));

    // ========================================
    // Helpers and reference model
    function automatic [31:0] xs(input [31:0] s);
        reg [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    function automatic [3:0] exp_code(input int s, input int e);
        return (e >= 2) ? 4 + e - 2 : s;
    endfunction
    task automatic chk(input [31:0] seen, input [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: saw %0h want %0h", $time, seen, exp);
        end
    endtask
    task automatic wr(input [7:0] a, input [7:0] d);
        ovps_host_i.xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input [7:0] a, input [7:0] e);
        ovps_host_i.xfer(1'b0, a, 8'h00, q);
        chk(q, e);
    endtask
    task automatic fault(input int k, input v);
        if (k == 0)
            ovp_above <= v;
        else
            curr_over <= v;
    endtask
    // Bounded wait for turn-on, then measure debounce and ramp
    task automatic turn_on(input int ramp);
        int t;
        t = 0;
        while (switch_on !== 1'b1 && t < 200) begin
            @(negedge clk);
            t++;
        end
        chk(t >= DEB && t <= DEB + 8, 1);
        n = 0;
        while (ramp_active === 1'b1 && n < 6000) begin
            @(negedge clk);
            n++;
        end
        chk(n >= ramp - 1 && n <= ramp + 1, 1);
    endtask
    task end_sim;
        if (error_cnt == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (40000) @(posedge clk);
        error_cnt++;
        end_sim();
    end
    // ========================================
    // Main sequence
    initial begin
        {rst, enable_n, temp_cool, adjust_above_min} = 4'hf;
        {uvlo_above, ovp_above, temp_hot, curr_over, otg_reverse} = 5'h0;
        measured_level = 8'h00;
        error_cnt = 0;
        samples_checked = 0;
        rnd_q = 32'd79194;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(negedge clk);
        chk(use_adjust_pin, 1);
        chk({ovp_code, 1'b0, threshold_trim}, 8'h03);
        rd(`OVPS_A_SLEW, 8'h04);
        rd(`OVPS_A_OVSEL, 8'h30);
        rd(8'h7c, 8'h00);
        for (int s = 0; s < 4; s++) begin
            for (int e = 0; e < 4; e++) begin
                rnd_q = xs(rnd_q);
                wr(`OVPS_A_OVSEL, {1'b0, rnd_q[2:0], 2'b00, s[1:0]});
                wr(`OVPS_A_EXTRA, {6'h0, e[1:0]});
                @(negedge clk);
                chk(ovp_code, exp_code(s, e));
                chk(threshold_trim, rnd_q[2:0]);
                chk(use_adjust_pin, 0);
            end
        end
        wr(`OVPS_A_SLEW, 8'h00);
        wr(`OVPS_A_ENABLE, 8'h00);
        @(posedge clk);
        enable_n <= 1'b0;
        uvlo_above <= 1'b1;
        turn_on(RAMP0);
        rd(`OVPS_A_STATUS, 8'h10);
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            fault(k, 1'b1);
            repeat (6) @(negedge clk);
            chk({switch_on, int_n}, 0);
            @(posedge clk);
            fault(k, 1'b0);
            turn_on(RAMP0);
            rd(`OVPS_A_FLAG, k ? 8'h02 : 8'h04);
            repeat (3) @(negedge clk);
            chk(int_n, 1);
        end
        // Hot die with reverse flow only reports
        @(posedge clk);
        {otg_reverse, temp_hot, temp_cool} <= 3'b110;
        repeat (6) @(negedge clk);
        chk({switch_on, int_n}, 2'b10);
        @(posedge clk);
        otg_reverse <= 1'b0;
        repeat (6) @(negedge clk);
        chk(switch_on, 0);
        @(posedge clk);
        temp_hot <= 1'b0;
        repeat (6) @(negedge clk);
        chk(switch_on, 0);
        @(posedge clk);
        temp_cool <= 1'b1;
        turn_on(RAMP0);
        rd(`OVPS_A_FLAG, 8'h01);
        @(posedge clk);
        uvlo_above <= 1'b0;
        rnd_q = xs(rnd_q);
        measured_level <= rnd_q[7:0];
        tgt = rnd_q[15:8];
        repeat (6) @(negedge clk);
        chk(switch_on, 0);
        wr(`OVPS_A_ENABLE, 8'hc0);
        repeat (10) @(posedge clk);
        wr(`OVPS_A_CURSRC, {4'h0, rnd_q[19:16]});
        wr(`OVPS_A_TIMING, 8'h00);
        wr(`OVPS_A_TARGET, tgt);
        chk({detect_active, source_current_code}, {1'b1, rnd_q[19:16]});
        repeat (20) @(negedge clk);
        chk(int_n, 0);
        rd(`OVPS_A_STATUS, (rnd_q[7:0] < tgt) ? 8'h60 : 8'h20);
        rd(`OVPS_A_MEASURED, rnd_q[7:0]);
        @(posedge clk);
        uvlo_above <= 1'b1;
        repeat (5) @(negedge clk);
        chk(detect_active, 0);
        @(posedge clk);
        enable_n <= 1'b1;
        repeat (6) @(negedge clk);
        chk({switch_on, int_n}, 2'b01);
        // Second reset with the strap low selects the internal default
        @(posedge clk);
        {rst, adjust_above_min} <= 2'b10;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(negedge clk);
        chk({use_adjust_pin, ovp_code, threshold_trim}, 8'h03);
        rd(`OVPS_A_OVSEL, 8'h30);
        end_sim();
    end
endmodule
